// ---- core/iefpb_pkg.sv ----
// constants for the interrupt enable, flag and priority register bank
package iefpb_pkg;
    // register word addresses, one aligned word each
    localparam logic [3:0] ADDR_CTRL_MAIN  = 4'h0;
    localparam logic [3:0] ADDR_CTRL_EDGE  = 4'h1;
    localparam logic [3:0] ADDR_CTRL_EXT   = 4'h2;
    localparam logic [3:0] ADDR_PER_FLAGS  = 4'h3;
    localparam logic [3:0] ADDR_PER_ENABLE = 4'h4;
    localparam logic [3:0] ADDR_PER_PRIO   = 4'h5;
    localparam logic [3:0] ADDR_RESET_CTRL = 4'h6;
    localparam logic [3:0] ADDR_VECTOR     = 4'h7;
    localparam logic [3:0] ADDR_PORT_B     = 4'h8;
    // main control fields
    localparam int MAIN_GLOBAL_HIGH = 7;
    localparam int MAIN_PERIPH_LOW  = 6;
    localparam int MAIN_T0_EN       = 5;
    localparam int MAIN_X0_EN       = 4;
    localparam int MAIN_PC_EN       = 3;
    localparam int MAIN_T0_FLAG     = 2;
    localparam int MAIN_X0_FLAG     = 1;
    localparam int MAIN_PC_FLAG     = 0;
    // edge and priority fields
    localparam int EDGE_PULLUP_DIS = 7;
    localparam int EDGE_X0_RISE    = 6;
    localparam int EDGE_X1_RISE    = 5;
    localparam int EDGE_T0_PRIO    = 2;
    localparam int EDGE_PC_PRIO    = 0;
    // external pin register fields
    localparam int EXT_X2_PRIO = 7;
    localparam int EXT_X1_PRIO = 6;
    localparam int EXT_X2_EN   = 4;
    localparam int EXT_X1_EN   = 3;
    localparam int EXT_X2_FLAG = 1;
    localparam int EXT_X1_FLAG = 0;
    // peripheral flag fields
    localparam int PER_PSP  = 7;
    localparam int PER_RX   = 5;
    localparam int PER_TX   = 4;
    localparam int RESET_CTRL_PRIO_MODE = 7;
    // writable masks and reset values
    localparam logic [7:0] EDGE_WMASK = 8'he5;
    localparam logic [7:0] EXT_WMASK  = 8'hdb;
    localparam logic [7:0] PER_WMASK  = 8'hcf;
    localparam logic [7:0] MAIN_RESET = 8'h00;
    localparam logic [7:0] EDGE_RESET = 8'he5;
    localparam logic [7:0] EXT_RESET  = 8'hc0;
    localparam logic [7:0] ZERO8      = 8'h00;
    localparam logic [7:0] PRIO_RESET = 8'hff;
    // vector addresses
    localparam logic [23:0] VEC_HIGH = 24'h00_0008;
    localparam logic [23:0] VEC_LOW  = 24'h00_0018;
endpackage : iefpb_pkg

// ---- core/iefpb_bank.sv ----
// interrupt enable, flag and priority register bank with avalon slave
`timescale 1ns/10ps
// Function
// - flags set on their event regardless of any enable bit
// - without priority mode, main bit 7 gates every interrupt
// - with priority mode, main bit 7 enables high priority interrupts
// - without priority mode, main bit 6 gates peripheral interrupts
// - with priority mode, main bit 6 enables low priority interrupts
// - timer0 overflow sets flag bit 2, enabled by bit 5
// - external pin0 sets flag bit 1, enabled by bit 4
// - upper port pin change sets flag bit 0, enabled by bit 3
// - mismatch keeps re-setting port-change flag until port read
// - edge select bits 6 and 5: one rising, zero falling
// - second register bit 7 disables all port pull-ups
// - per-source priority bit one is high, zero is low
// - pins 2 and 1 enables bits 4,3, flags bits 1,0
// - unimplemented control bits read as zero
// - parallel port access and conversion done flags, software cleared
// - receive flag follows buffer full, cleared by buffer read
// - transmit flag follows buffer empty, cleared by buffer write
// - sync serial completion flag, software cleared
// - capture/compare flag from capture or compare, unused in pwm
// - timer2 match bit 1, timer1 overflow bit 0
// - small variant: parallel port flag reads zero
// - priority mode bit in reset control; off ignores priority bits
// - high requests vector 000008h, low 000018h, high preempts low
// - accepting an interrupt clears the applicable global enable
module iefpb_bank #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // event sources; pins and serial buffer states are levels, the others one-cycle pulses
    input  wire logic        timer0_overflow_i,
    input  wire logic        ext_pin0_i,
    input  wire logic        ext_pin1_i,
    input  wire logic        ext_pin2_i,
    input  wire logic [3:0]  upper_port_pins_i,
    input  wire logic        parallel_access_i,
    input  wire logic        conversion_done_i,
    input  wire logic        serial_receive_full_i,
    input  wire logic        serial_transmit_empty_i,
    input  wire logic        sync_serial_done_i,
    input  wire logic        ccp_capture_i,
    input  wire logic        ccp_compare_i,
    input  wire logic [1:0]  ccp_mode_i,
    input  wire logic        timer2_match_i,
    input  wire logic        timer1_overflow_i,
    // serial buffer accesses seen by the core
    output logic             serial_receive_read_o,
    output logic             serial_transmit_write_o,
    // core interface
    input  wire logic        core_accept_i,
    input  wire logic        core_return_i,
    input  wire logic        core_return_high_i,
    output logic             irq_high_o,
    output logic             irq_low_o,
    output logic [23:0]      irq_vector_o,
    output logic             port_pullup_disable_o
);
    // ccp mode codes: 0 capture, 1 compare, other pwm
    localparam logic [1:0] CCP_CAPTURE = 2'h0;
    localparam logic [1:0] CCP_COMPARE = 2'h1;

    logic [7:0] ctrl_main;
    logic [7:0] ctrl_edge;
    logic [7:0] ctrl_ext;
    logic [7:0] per_flags;
    logic [7:0] per_enable;
    logic [7:0] per_prio;
    logic       priority_mode_enable;
    logic [3:0] port_latch;
    logic [2:0] ext_prev;
    logic       in_low_service;
    logic [7:0] next_main;
    logic [7:0] next_ext;
    logic [7:0] next_per;
    logic       accept_high;
    logic       accept_low;
    // pins are unknown at reset, so the first sample after reset only primes ext_prev
    logic       ext_armed;

    // bus decode; waitrequest low always, one-cycle answer
    wire       wr_en     = avs_write_i & avs_byteenable_i[0];
    wire [7:0] wdata     = avs_writedata_i[7:0];
    wire       wr_main   = wr_en & (avs_address_i == iefpb_pkg::ADDR_CTRL_MAIN);
    wire       wr_edge   = wr_en & (avs_address_i == iefpb_pkg::ADDR_CTRL_EDGE);
    wire       wr_ext    = wr_en & (avs_address_i == iefpb_pkg::ADDR_CTRL_EXT);
    wire       wr_per    = wr_en & (avs_address_i == iefpb_pkg::ADDR_PER_FLAGS);
    wire       wr_pen    = wr_en & (avs_address_i == iefpb_pkg::ADDR_PER_ENABLE);
    wire       wr_ppr    = wr_en & (avs_address_i == iefpb_pkg::ADDR_PER_PRIO);
    wire       wr_rst    = wr_en & (avs_address_i == iefpb_pkg::ADDR_RESET_CTRL);
    wire       rd_port   = avs_read_i & (avs_address_i == iefpb_pkg::ADDR_PORT_B);
    assign avs_waitrequest_o = 1'b0;

    // edge detection on the external pins, sense chosen for pins 0 and 1, pin 2 rising only
    wire x0_rise = ctrl_edge[iefpb_pkg::EDGE_X0_RISE];
    wire x1_rise = ctrl_edge[iefpb_pkg::EDGE_X1_RISE];
    wire x0_evt  = ext_armed
                 & (x0_rise ? (ext_pin0_i & ~ext_prev[0]) : (~ext_pin0_i & ext_prev[0]));
    wire x1_evt  = ext_armed
                 & (x1_rise ? (ext_pin1_i & ~ext_prev[1]) : (~ext_pin1_i & ext_prev[1]));
    wire x2_evt  = ext_armed & ext_pin2_i & ~ext_prev[2];
    // mismatch stays true until a port read refreshes the latch
    wire pc_mismatch = |(upper_port_pins_i ^ port_latch);

    // capture/compare event only in capture or compare mode
    wire ccp_evt = ((ccp_mode_i == CCP_CAPTURE) & ccp_capture_i)
                 | ((ccp_mode_i == CCP_COMPARE) & ccp_compare_i);
    wire psp_ok  = LARGE_VARIANT;

    // main register: software write first, hardware set wins
    always_comb begin
        next_main = wr_main ? wdata : ctrl_main;
        if (timer0_overflow_i) begin
            next_main[iefpb_pkg::MAIN_T0_FLAG] = 1'b1;
        end
        if (x0_evt) begin
            next_main[iefpb_pkg::MAIN_X0_FLAG] = 1'b1;
        end
        if (pc_mismatch) begin
            next_main[iefpb_pkg::MAIN_PC_FLAG] = 1'b1;
        end
        if (accept_high) begin
            next_main[iefpb_pkg::MAIN_GLOBAL_HIGH] = 1'b0;
        end else if (accept_low) begin
            next_main[iefpb_pkg::MAIN_PERIPH_LOW] = 1'b0;
        end
        if (core_return_i) begin
            if (!priority_mode_enable || core_return_high_i) begin
                next_main[iefpb_pkg::MAIN_GLOBAL_HIGH] = 1'b1;
            end else begin
                next_main[iefpb_pkg::MAIN_PERIPH_LOW] = 1'b1;
            end
        end
    end

    // external pins register; unimplemented bits held at zero
    always_comb begin
        next_ext = wr_ext ? (wdata & iefpb_pkg::EXT_WMASK) : ctrl_ext;
        if (x1_evt) begin
            next_ext[iefpb_pkg::EXT_X1_FLAG] = 1'b1;
        end
        if (x2_evt) begin
            next_ext[iefpb_pkg::EXT_X2_FLAG] = 1'b1;
        end
    end

    // peripheral flags; receive and transmit track their buffers
    always_comb begin
        next_per = wr_per ? (wdata & iefpb_pkg::PER_WMASK) : per_flags;
        next_per[iefpb_pkg::PER_RX] = serial_receive_full_i;
        next_per[iefpb_pkg::PER_TX] = serial_transmit_empty_i;
        if (parallel_access_i) begin
            next_per[7] = 1'b1;
        end
        if (conversion_done_i) begin
            next_per[6] = 1'b1;
        end
        if (sync_serial_done_i) begin
            next_per[3] = 1'b1;
        end
        if (ccp_evt) begin
            next_per[2] = 1'b1;
        end
        if (timer2_match_i) begin
            next_per[1] = 1'b1;
        end
        if (timer1_overflow_i) begin
            next_per[0] = 1'b1;
        end
        next_per[iefpb_pkg::PER_PSP] = next_per[iefpb_pkg::PER_PSP] & psp_ok;
    end

    // per-source pending: flag and enable
    wire t0_p = ctrl_main[iefpb_pkg::MAIN_T0_FLAG] & ctrl_main[iefpb_pkg::MAIN_T0_EN];
    wire x0_p = ctrl_main[iefpb_pkg::MAIN_X0_FLAG] & ctrl_main[iefpb_pkg::MAIN_X0_EN];
    wire pc_p = ctrl_main[iefpb_pkg::MAIN_PC_FLAG] & ctrl_main[iefpb_pkg::MAIN_PC_EN];
    wire x1_p = ctrl_ext[iefpb_pkg::EXT_X1_FLAG] & ctrl_ext[iefpb_pkg::EXT_X1_EN];
    wire x2_p = ctrl_ext[iefpb_pkg::EXT_X2_FLAG] & ctrl_ext[iefpb_pkg::EXT_X2_EN];
    wire [7:0] per_p = per_flags & per_enable;
    // priority bits; external pin 0 is always high priority
    wire t0_hi = ctrl_edge[iefpb_pkg::EDGE_T0_PRIO];
    wire pc_hi = ctrl_edge[iefpb_pkg::EDGE_PC_PRIO];
    wire x1_hi = ctrl_ext[iefpb_pkg::EXT_X1_PRIO];
    wire x2_hi = ctrl_ext[iefpb_pkg::EXT_X2_PRIO];
    wire core_any_hi = x0_p | (t0_p & t0_hi) | (pc_p & pc_hi) | (x1_p & x1_hi) | (x2_p & x2_hi);
    wire core_any_lo = (t0_p & ~t0_hi) | (pc_p & ~pc_hi) | (x1_p & ~x1_hi) | (x2_p & ~x2_hi);
    wire per_any_hi  = |(per_p & per_prio);
    wire per_any_lo  = |(per_p & ~per_prio);
    wire core_any    = t0_p | x0_p | pc_p | x1_p | x2_p;
    wire g_hi        = ctrl_main[iefpb_pkg::MAIN_GLOBAL_HIGH];
    wire g_lo        = ctrl_main[iefpb_pkg::MAIN_PERIPH_LOW];

    // request gating by mode
    wire compat_req = g_hi & (core_any | (g_lo & (|per_p)));
    wire high_req   = g_hi & (core_any_hi | per_any_hi);
    wire low_req    = g_lo & (core_any_lo | per_any_lo) & ~in_low_service;
    wire req_high   = priority_mode_enable ? high_req : compat_req;
    wire req_low    = priority_mode_enable & low_req & ~req_high;
    assign accept_high = core_accept_i & req_high;
    assign accept_low  = core_accept_i & req_low;
    assign irq_high_o   = req_high;
    assign irq_low_o    = req_low;
    assign irq_vector_o = req_low ? iefpb_pkg::VEC_LOW : iefpb_pkg::VEC_HIGH;
    assign port_pullup_disable_o = ctrl_edge[iefpb_pkg::EDGE_PULLUP_DIS];

    // register update
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_main            <= iefpb_pkg::MAIN_RESET;
            ctrl_edge            <= iefpb_pkg::EDGE_RESET;
            ctrl_ext             <= iefpb_pkg::EXT_RESET;
            per_flags            <= iefpb_pkg::ZERO8;
            per_enable           <= iefpb_pkg::ZERO8;
            per_prio             <= iefpb_pkg::PRIO_RESET;
            priority_mode_enable <= 1'b0;
            port_latch           <= 4'h0;
            ext_prev             <= 3'h0;
            ext_armed            <= 1'b0;
            in_low_service       <= 1'b0;
        end else begin
            ext_armed <= 1'b1;
            ctrl_main <= next_main;
            ctrl_ext  <= next_ext;
            per_flags <= next_per;
            ext_prev  <= {ext_pin2_i, ext_pin1_i, ext_pin0_i};
            if (wr_edge) begin
                ctrl_edge <= wdata & iefpb_pkg::EDGE_WMASK;
            end
            if (wr_pen) begin
                per_enable <= wdata;
            end
            if (wr_ppr) begin
                per_prio <= wdata;
            end
            if (wr_rst) begin
                priority_mode_enable <= wdata[iefpb_pkg::RESET_CTRL_PRIO_MODE];
            end
            if (rd_port) begin
                port_latch <= upper_port_pins_i;
            end
            if (accept_low) begin
                in_low_service <= 1'b1;
            end else if (core_return_i && !core_return_high_i) begin
                in_low_service <= 1'b0;
            end
        end
    end

    // read mux, combinational; unmapped reads return zero
    logic [7:0] rd_mux;
    always_comb begin
        case (avs_address_i)
            iefpb_pkg::ADDR_CTRL_MAIN:  rd_mux = ctrl_main;
            iefpb_pkg::ADDR_CTRL_EDGE:  rd_mux = ctrl_edge;
            iefpb_pkg::ADDR_CTRL_EXT:   rd_mux = ctrl_ext;
            iefpb_pkg::ADDR_PER_FLAGS:  rd_mux = per_flags;
            iefpb_pkg::ADDR_PER_ENABLE: rd_mux = per_enable;
            iefpb_pkg::ADDR_PER_PRIO:   rd_mux = per_prio;
            iefpb_pkg::ADDR_RESET_CTRL: rd_mux = {priority_mode_enable, 7'h00};
            iefpb_pkg::ADDR_VECTOR:     rd_mux = irq_vector_o[7:0];
            iefpb_pkg::ADDR_PORT_B:     rd_mux = {upper_port_pins_i, 4'h0};
            default:                    rd_mux = iefpb_pkg::ZERO8;
        endcase
    end
    // readdata combinational with zero wait, valid at the sampling edge
    assign avs_readdata_o = avs_read_i ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    // buffer access strobes toward the serial unit, which clears its own state
    assign serial_receive_read_o   = avs_read_i & (avs_address_i == iefpb_pkg::ADDR_PER_FLAGS);
    assign serial_transmit_write_o = wr_per;
endmodule : iefpb_bank

// ---- verif/iefpb_properties.sv ----
// port-level assertions for the interrupt register bank
`timescale 1ns/10ps
module iefpb_properties (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        srst_i,
    // register bus
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    // core side
    input wire logic        core_accept_i,
    input wire logic        core_return_i,
    input wire logic        irq_high_o,
    input wire logic        irq_low_o,
    input wire logic [23:0] irq_vector_o,
    input wire logic        port_pullup_disable_o,
    input wire logic        serial_receive_read_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);
    // decodes; only a low-lane write to the edge register may move the pull-up
    wire rd_edge = avs_read_i && avs_address_i == 4'h1;
    wire rd_ext  = avs_read_i && avs_address_i == 4'h2;
    wire rd_per  = avs_read_i && avs_address_i == 4'h3;
    wire wr_edge = avs_write_i && avs_byteenable_i[0] && avs_address_i == 4'h1;
    // a write load, and a take of a lone high request with no return beside it
    sequence s_load;
        wr_edge;
    endsequence
    sequence s_take;
        core_accept_i && irq_high_o && !irq_low_o && !core_return_i && !avs_write_i;
    endsequence
    a_idle_read_zero: assert property (!avs_read_i |-> avs_readdata_o == 32'h0000_0000)
        else $error("readdata set without a read");
    a_edge_gap_zero: assert property (rd_edge |-> (avs_readdata_o[7:0] & 8'h1a) == 8'h00)
        else $error("edge register gap bits set");
    a_ext_gap_zero: assert property (rd_ext |-> (avs_readdata_o[7:0] & 8'h24) == 8'h00)
        else $error("pin register gap bits set");
    a_rx_read_strobe: assert property (serial_receive_read_o == rd_per)
        else $error("receive read strobe wrong");
    a_pullup_load: assert property (s_load |=>
        port_pullup_disable_o == $past(avs_writedata_i[7])) else $error("pull-up not loaded");
    a_pullup_hold: assert property (!wr_edge |=> $stable(port_pullup_disable_o))
        else $error("pull-up moved without a write");
    a_take_clears: assert property (s_take |=> !irq_high_o)
        else $error("high request kept after take");
    a_vector_low: assert property (irq_low_o && !irq_high_o |-> irq_vector_o == 24'h00_0018)
        else $error("low vector wrong");
    a_vector_high: assert property (!irq_low_o |-> irq_vector_o == 24'h00_0008)
        else $error("high vector wrong");
endmodule : iefpb_properties
bind iefpb_bank iefpb_properties u_props (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .core_accept_i(core_accept_i), .core_return_i(core_return_i), .irq_high_o(irq_high_o),
    .irq_low_o(irq_low_o), .irq_vector_o(irq_vector_o),
    .port_pullup_disable_o(port_pullup_disable_o),
    .serial_receive_read_o(serial_receive_read_o));

// ---- verif/iefpb_core_model.sv ----
// behavioural core that takes interrupt requests and returns from them
`timescale 1ns/10ps
module iefpb_core_model (
    // clock, reset and bench control
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       en_i,
    input  wire logic [3:0] dly_i,
    // requests in, answers out
    input  wire logic       irq_high_i,
    input  wire logic       irq_low_i,
    output logic            accept_o,
    output logic            return_o,
    output logic            return_high_o,
    output int              taken_o
);
    int   cnt;
    logic busy;
    // dly_i cycles before a take; the bench takes once, with dly_i at 6
    always_ff @(posedge clk_i) begin
        accept_o <= 1'b0;
        return_o <= 1'b0;
        cnt      <= (busy || (en_i && (irq_high_i || irq_low_i))) ? cnt + 1 : 0;
        if (srst_i) begin
            busy          <= 1'b0;
            taken_o       <= 0;
            cnt           <= 0;
            return_high_o <= 1'b0;
        end else if (busy && cnt == 8) begin
            return_o <= 1'b1;
            busy     <= 1'b0;
            cnt      <= 0;
        end else if (!busy && cnt >= dly_i && en_i && (irq_high_i || irq_low_i)) begin
            accept_o      <= 1'b1;
            return_high_o <= irq_high_i;
            busy          <= 1'b1;
            cnt           <= 0;
            taken_o       <= taken_o + 1;
        end
    end
endmodule : iefpb_core_model

// ---- verif/testbench.sv ----
// self-checking bench for the interrupt register bank
`timescale 1ns/10ps
module testbench;
    // bus, event sources and core handshake
    logic        sys_clk_i = 1'b0, srst_i = 1'b1, rd = 1'b0, wr = 1'b0, t0 = 1'b0;
    logic        cmp = 1'b0, rx_full = 1'b0, tx_empty = 1'b0, en = 1'b0;
    logic        wait_req, hi, lo, acc, ret, ret_hi, pud, rxr, txw;
    logic [3:0]  addr = 4'h0, be = 4'h0, pins = 4'h0, dly = 4'h2;
    logic [2:0]  xp = 3'b011;
    logic [1:0]  mode = 2'h0;
    logic [7:0]  ev = 8'h00, pf = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [23:0] vec;
    logic [31:0] exp_q[$];
    int          seed = 32'h0000_dbad, failures = 0, num_checks = 0, taken;
    iefpb_bank dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .timer0_overflow_i(t0),
        .ext_pin0_i(xp[0]), .ext_pin1_i(xp[1]), .ext_pin2_i(xp[2]), .upper_port_pins_i(pins),
        .parallel_access_i(ev[7]), .conversion_done_i(ev[6]), .serial_receive_full_i(rx_full),
        .serial_transmit_empty_i(tx_empty), .sync_serial_done_i(ev[3]), .ccp_capture_i(ev[2]),
        .ccp_compare_i(cmp), .ccp_mode_i(mode), .timer2_match_i(ev[1]),
        .timer1_overflow_i(ev[0]), .serial_receive_read_o(rxr), .serial_transmit_write_o(txw),
        .core_accept_i(acc), .core_return_i(ret), .core_return_high_i(ret_hi), .irq_high_o(hi),
        .irq_low_o(lo), .irq_vector_o(vec), .port_pullup_disable_o(pud));
    iefpb_core_model core (.clk_i(sys_clk_i), .srst_i(srst_i), .en_i(en), .dly_i(dly),
        .irq_high_i(hi), .irq_low_i(lo), .accept_o(acc), .return_o(ret),
        .return_high_o(ret_hi), .taken_o(taken));
    // every comparison goes through here
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // request levels, and the vector whenever one is raised
    task automatic chk_irq(input logic h, input logic l);
        chk("irq_high_o", 32'(h), 32'(hi));
        chk("irq_low_o", 32'(l), 32'(lo));
        if (h | l) chk("irq_vector_o", l ? 32'h0000_0018 : 32'h0000_0008, 32'(vec));
    endtask : chk_irq
    // one bus cycle held until waitrequest is low; a read notes its expected data
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        if (!w) exp_q.push_back({24'h00_0000, d});
        addr  <= a;
        rd    <= !w;
        wr    <= w;
        wdata <= {24'($random(seed)), d};
        be    <= {3'($random(seed)), 1'b1};
        do @(posedge sys_clk_i); while (wait_req !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus
    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // read data taken at the edge where the slave answers
    always @(posedge sys_clk_i)
    begin
        if (rd && wait_req === 1'b0) chk("avs_readdata_o", exp_q.pop_front(), rdata);
        if (wr && wait_req === 1'b0)
            chk("serial_transmit_write_o", 32'(be[0] && addr == 4'h3), 32'(txw));
    end
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        // reset values, masks and an unmapped place
        bus(0, 4'h0, 8'h00);
        bus(0, 4'h2, 8'hc0);
        bus(1, 4'hf, 8'hff);
        bus(0, 4'hf, 8'h00);
        chk("port_pullup_disable_o", 32'h1, 32'(pud));
        bus(1, 4'h1, 8'hff);
        bus(0, 4'h1, 8'he5);
        bus(1, 4'h1, 8'h00);
        chk("port_pullup_disable_o", 32'h0, 32'(pud));
        $display("test registers done");
        // falling edges first, then rising; every enable is off
        xp <= 3'b100;
        repeat (2) @(posedge sys_clk_i);
        bus(0, 4'h0, 8'h02);
        bus(0, 4'h2, 8'hc3);
        bus(1, 4'h1, 8'h60);
        bus(1, 4'h0, 8'h00);
        bus(1, 4'h2, 8'h00);
        xp <= 3'b011;
        repeat (2) @(posedge sys_clk_i);
        bus(0, 4'h0, 8'h02);
        bus(0, 4'h2, 8'h01);
        t0 <= 1'b1;
        @(posedge sys_clk_i);
        t0 <= 1'b0;
        bus(0, 4'h0, 8'h06);
        // pin change keeps its flag up until the port is read
        pins <= 4'h8 | 4'($random(seed));
        repeat (2) @(posedge sys_clk_i);
        bus(1, 4'h0, 8'h00);
        bus(0, 4'h0, 8'h01);
        bus(0, 4'h8, {pins, 4'h0});
        bus(1, 4'h0, 8'h00);
        bus(0, 4'h0, 8'h00);
        $display("test event flags done");
        // each peripheral event lands in its own bit
        for (int i = 0; i < 8; i++) begin
            if (i == 4 || i == 5) continue;
            ev <= 8'(1 << i);
            @(posedge sys_clk_i);
            ev <= 8'h00;
            pf = pf | 8'(1 << i);
            bus(0, 4'h3, pf);
        end
        bus(1, 4'h3, 8'h00);
        mode <= 2'h2;
        ev   <= 8'h04;
        @(posedge sys_clk_i);
        ev   <= 8'h00;
        mode <= 2'h1;
        cmp  <= 1'b1;
        @(posedge sys_clk_i);
        cmp      <= 1'b0;
        rx_full  <= 1'b1;
        tx_empty <= 1'b1;
        @(posedge sys_clk_i);
        bus(0, 4'h3, 8'h34);
        $display("test peripheral flags done");
        // global gate, take by the core, automatic clear and return
        bus(1, 4'h0, 8'h24);
        chk_irq(0, 0);
        dly <= 4'h6;
        en  <= 1'b1;
        bus(1, 4'h0, 8'ha4);
        chk_irq(1, 0);
        while (taken == 0) @(posedge sys_clk_i);
        en <= 1'b0;
        @(posedge sys_clk_i);
        bus(0, 4'h0, 8'h24);
        repeat (10) @(posedge sys_clk_i);
        bus(0, 4'h0, 8'ha4);
        bus(1, 4'h0, 8'h80);
        bus(1, 4'h4, 8'h01);
        ev <= 8'h01;
        @(posedge sys_clk_i);
        ev <= 8'h00;
        @(posedge sys_clk_i);
        chk_irq(0, 0);
        bus(1, 4'h0, 8'hc0);
        chk_irq(1, 0);
        // priority mode: bit 6 gates low, bit 7 gates high
        bus(1, 4'h6, 8'h80);
        bus(1, 4'h5, 8'h00);
        chk_irq(0, 1);
        bus(1, 4'h0, 8'h80);
        chk_irq(0, 0);
        bus(1, 4'h5, 8'h01);
        chk_irq(1, 0);
        bus(1, 4'h0, 8'h40);
        chk_irq(0, 0);
        bus(1, 4'h6, 8'h00);
        bus(1, 4'h5, 8'h00);
        bus(1, 4'h0, 8'hc0);
        chk_irq(1, 0);
        $display("test requests done");
        report_and_stop();
    end
endmodule : testbench
